// file: common/sso_cfg.svh
// Contract
// RQ1 - switchover enabled at reset; config bit 1 set keeps main supply always
// RQ2 - source status bit 6 reads 1 on main supply, 0 on battery
// RQ3 - select field 0b01: dc input below 1.2 V moves rail to battery
// RQ4 - select field zero: main supply below 2.75 V moves rail to battery
// RQ5 - irq1 field 0bX01: battery-control pin falling edge moves rail to battery
// RQ6 - return needs main above 2.75 V and, if enabled, dc above 1.2 V
// RQ7 - with pin enabled, return also needs battery-control pin high
// RQ8 - source switching never resets or halts the core
// RQ9 - metering ADCs flagged unavailable while battery feeds the rail
// RQ10 - shared interrupt off at reset; gated by enable bit 1 of enable reg two
// RQ11 - interrupt raised only for flags whose enable bit is set
// RQ12 - flags set on events regardless of enable bits
// RQ13 - flags latched until software writes 0 to the bit
// RQ14 - main to battery change sets flag bit 1, enable bit 1
// RQ15 - battery to main change sets flag bit 7, enable bit 7
// RQ16 - dc delta beyond threshold is an event, enable bit 3
// RQ17 - dc conversion periodic or on start write; ready flag set on result
// RQ18 - battery flag bit 2 on low reading or new reading, enable bit 2
// RQ19 - dc low flag bit 0 from comparator below 1.2 V, enable bit 0
// RQ20 - sag flag bit 5 on sustained line sag, enable bit 5
// RQ21 - dc-triggered switchover about 30 ms after dc drops
// RQ22 - wait about 130 ms after restore conditions before reconnecting
// RQ23 - comparators and pin synchronised before edge detection
`ifndef SSO_CFG_SVH
`define SSO_CFG_SVH
`define SSO_ADR_IRQEN2      8'ha9
`define SSO_ADR_ENABLE      8'hec
`define SSO_ADR_PERCFG      8'hf4
`define SSO_ADR_SWCFG       8'hf5
`define SSO_ADR_FLAGS       8'hf8
`define SSO_ADR_INTPIN      8'hff
`define SSO_ADR_CONVGO      8'hd8
`define SSO_BIT_DCLOW       0
`define SSO_BIT_SWO         1
`define SSO_BIT_BAT         2
`define SSO_BIT_DCDELTA     3
`define SSO_BIT_SAG         5
`define SSO_BIT_RESTORE     7
`define SSO_BIT_SRC         6
`define SSO_BIT_DISABLE     1
`define SSO_BIT_IRQ_GATE    1
`define SSO_FLAG_MASK       8'hbf
`define SSO_CLK_HZ          40000000
`define SSO_DC_DELAY_MS     30
`define SSO_RESTORE_MS      130
`define SSO_DC_CYC          ((`SSO_CLK_HZ / 1000) * `SSO_DC_DELAY_MS)
`define SSO_RESTORE_CYC     ((`SSO_CLK_HZ / 1000) * `SSO_RESTORE_MS)
`endif

// file: common/sso_pkg.sv
package sso_pkg;
  typedef enum logic [1:0] {
    SSO_MAIN,
    SSO_DC_WAIT,
    SSO_BATT,
    SSO_RESTORE
  } sso_state_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sso_sfr_req_t;
  typedef struct packed {
    logic dc_low;
    logic dc_delta;
    logic dc_ready;
    logic bat_low;
    logic bat_new;
    logic sag;
  } sso_evt_t;
endpackage

// file: design/sso_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sso_cfg.svh"
module sso_top #(
  parameter int unsigned DC_CYC      = `SSO_DC_CYC,
  parameter int unsigned RESTORE_CYC = `SSO_RESTORE_CYC,
  parameter int unsigned CNT_W       = 23
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire sso_pkg::sso_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  input  wire logic                  main_ok_async,
  input  wire logic                  dc_ok_async,
  input  wire logic                  batt_ctrl_async,
  input  wire sso_pkg::sso_evt_t     evt,
  output logic                       rail_on_main,
  output logic                       metering_adc_avail,
  output logic                       dc_conv_start,
  output logic                       power_irq
);
  import sso_pkg::*;

  // ==========================================================
  // reset and input synchronisers
  // ==========================================================
  logic       rst_s1_ff;
  logic       rst_n_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic       pin_prev_ff;

  // reset released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // RQ23 two-flop sync
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= {batt_ctrl_async, dc_ok_async, main_ok_async};
      sync2_ff <= sync1_ff;
    end
  end

  logic main_ok;
  logic dc_ok;
  logic pin_hi;
  assign main_ok = sync2_ff[0];
  assign dc_ok   = sync2_ff[1];
  assign pin_hi  = sync2_ff[2];

  // RQ23 edge on synced pin
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_prev_ff <= 1'b1;
    end else begin
      pin_prev_ff <= pin_hi;
    end
  end

  logic pin_fall;
  assign pin_fall = pin_prev_ff & ~pin_hi;

  // ==========================================================
  // special function registers
  // ==========================================================
  logic [7:0] irqen2_ff;
  logic [7:0] enable_ff;
  logic [7:0] percfg_ff;
  logic [7:0] swcfg_ff;
  logic [7:0] intpin_ff;
  logic [7:0] flags_ff;
  logic       dc_start_ff;

  logic wr_irqen2;
  logic wr_enable;
  logic wr_percfg;
  logic wr_swcfg;
  logic wr_intpin;
  logic wr_flags;
  assign wr_irqen2 = sfr_req.wr && (sfr_req.addr == `SSO_ADR_IRQEN2);
  assign wr_enable = sfr_req.wr && (sfr_req.addr == `SSO_ADR_ENABLE);
  assign wr_percfg = sfr_req.wr && (sfr_req.addr == `SSO_ADR_PERCFG);
  assign wr_swcfg  = sfr_req.wr && (sfr_req.addr == `SSO_ADR_SWCFG);
  assign wr_intpin = sfr_req.wr && (sfr_req.addr == `SSO_ADR_INTPIN);
  assign wr_flags  = sfr_req.wr && (sfr_req.addr == `SSO_ADR_FLAGS);

  // RQ1 RQ10 plain rw registers, all zero at reset
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irqen2_ff <= 8'h00;
      enable_ff <= 8'h00;
      percfg_ff <= 8'h00;
      swcfg_ff  <= 8'h00;
      intpin_ff <= 8'h00;
    end else begin
      if (wr_irqen2) irqen2_ff <= sfr_req.wdata;
      if (wr_enable) enable_ff <= sfr_req.wdata;
      if (wr_percfg) percfg_ff <= sfr_req.wdata;
      if (wr_swcfg)  swcfg_ff  <= sfr_req.wdata;
      if (wr_intpin) intpin_ff <= sfr_req.wdata;
    end
  end

  // RQ17 start strobe on write of the start register
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dc_start_ff <= 1'b0;
    end else begin
      dc_start_ff <= sfr_req.wr && (sfr_req.addr == `SSO_ADR_CONVGO);
    end
  end
  assign dc_conv_start = dc_start_ff;

  // ==========================================================
  // switchover controller
  // ==========================================================
  sso_state_t       state_ff;
  sso_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             to_batt_pulse;
  logic             to_main_pulse;

  logic sw_disabled;
  logic sel_dc;
  logic sel_main;
  logic pin_en;
  logic restore_ok;
  assign sw_disabled = swcfg_ff[`SSO_BIT_DISABLE];
  assign sel_dc      = (swcfg_ff[1:0] == 2'b01);
  assign sel_main    = (swcfg_ff[1:0] == 2'b00);
  assign pin_en      = (intpin_ff[2:1] == 2'b01);

  // RQ6 RQ7 all enabled return conditions at once
  assign restore_ok = main_ok && (!sel_dc || dc_ok) && (!pin_en || pin_hi);

  // RQ8 only the rail moves; no reset or halt is produced here
  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    to_batt_pulse = 1'b0;
    to_main_pulse = 1'b0;
    unique case (state_ff)
      SSO_MAIN: begin
        // RQ1 disable bit keeps main selected
        if (sw_disabled) begin
          nxt_state = SSO_MAIN;
        // RQ4 RQ5 immediate moves
        end else if ((sel_main && !main_ok) || (pin_en && pin_fall)) begin
          nxt_state     = SSO_BATT;
          to_batt_pulse = 1'b1;
        // RQ3 dc input low starts the delay
        end else if (sel_dc && !dc_ok) begin
          nxt_state = SSO_DC_WAIT;
          nxt_cnt   = '0;
        end
      end
      SSO_DC_WAIT: begin
        if (sw_disabled || dc_ok) begin
          nxt_state = SSO_MAIN;
        end else if ((pin_en && pin_fall) || cnt_ff >= CNT_W'(DC_CYC - 1)) begin
          // RQ21 move after the dc delay
          nxt_state     = SSO_BATT;
          to_batt_pulse = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      SSO_BATT: begin
        if (restore_ok || sw_disabled) begin
          nxt_state = SSO_RESTORE;
          nxt_cnt   = '0;
        end
      end
      SSO_RESTORE: begin
        if (!restore_ok && !sw_disabled) begin
          nxt_state = SSO_BATT;
        end else if (cnt_ff >= CNT_W'(RESTORE_CYC - 1)) begin
          // RQ22 reconnect after restore delay
          nxt_state     = SSO_MAIN;
          to_main_pulse = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    endcase
  end

  // controller state and delay counter
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= SSO_MAIN;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // RQ2 main while not on battery
  logic on_batt;
  assign on_batt            = (state_ff == SSO_BATT) || (state_ff == SSO_RESTORE);
  assign rail_on_main       = ~on_batt;
  // RQ9 metering adc unavailable on battery
  assign metering_adc_avail = ~on_batt;

  // ==========================================================
  // power event flags and interrupt
  // ==========================================================
  logic [7:0] set_vec;
  always_comb begin
    set_vec = 8'h00;
    // RQ12 RQ19 dc low comparator
    set_vec[`SSO_BIT_DCLOW]   = evt.dc_low;
    // RQ14 switchover event
    set_vec[`SSO_BIT_SWO]     = to_batt_pulse;
    // RQ18 battery low or new reading
    set_vec[`SSO_BIT_BAT]     = evt.bat_low | evt.bat_new;
    // RQ16 RQ17 delta event or conversion ready
    set_vec[`SSO_BIT_DCDELTA] = evt.dc_delta | evt.dc_ready;
    // RQ20 line sag
    set_vec[`SSO_BIT_SAG]     = evt.sag;
    // RQ15 restore event
    set_vec[`SSO_BIT_RESTORE] = to_main_pulse;
  end

  // RQ13 write zero clears; a same-cycle set wins
  // the set is merged after the clear so an event in the clearing cycle survives
  logic [7:0] nxt_flags;
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_flags) begin
      nxt_flags = flags_ff & sfr_req.wdata;
    end
    nxt_flags = (nxt_flags | set_vec) & `SSO_FLAG_MASK;
  end

  // flag register; bit 6 never holds a one
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // RQ11 flags that may interrupt
  logic [7:0] pend;
  assign pend = flags_ff & enable_ff;

  // RQ10 RQ11 gated shared request, registered
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      power_irq <= 1'b0;
    end else begin
      power_irq <= irqen2_ff[`SSO_BIT_IRQ_GATE] && (|pend);
    end
  end

  // ==========================================================
  // read data path
  // ==========================================================
  // RQ2 live source bit over the stored peripheral bits
  logic [7:0] percfg_view;
  always_comb begin
    percfg_view               = percfg_ff;
    percfg_view[`SSO_BIT_SRC] = rail_on_main;
  end

  // read mux; unmapped addresses read zero
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = sfr_rdata;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        `SSO_ADR_IRQEN2: nxt_rdata = irqen2_ff;
        `SSO_ADR_ENABLE: nxt_rdata = enable_ff;
        `SSO_ADR_PERCFG: nxt_rdata = percfg_view;
        `SSO_ADR_SWCFG:  nxt_rdata = swcfg_ff;
        `SSO_ADR_FLAGS:  nxt_rdata = flags_ff;
        `SSO_ADR_INTPIN: nxt_rdata = intpin_ff;
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data holds until the next read, so a slow core can fetch it late
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= nxt_rdata;
    end
  end
endmodule
`default_nettype wire

// file: verif/sso_partner.sv
`timescale 1ns/10ps
`default_nettype none
module sso_partner (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [2:0] want,
  output logic [2:0]      lvl
);
  // ==================================================
  // comparators and pin: {main_ok, dc_ok, batt_ctrl}
  logic [2:0] dly_ff;
  // slow mode lags the wanted levels by one core cycle
  always_ff @(posedge clk) begin
    dly_ff <= want;
  end
  // comparator and pin levels driven from the far side
  assign lvl = slow ? dly_ff : want;
endmodule
`default_nettype wire

// file: verif/sso_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sso_top_asserts #(
  parameter int unsigned RESTORE_CYC = 20
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire sso_pkg::sso_sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  main_ok_async,
  input wire logic                  rail_on_main,
  input wire logic                  metering_adc_avail,
  input wire logic                  dc_conv_start,
  input wire logic                  power_irq
);
  import sso_pkg::*;
  // ==================================================
  // shadow of control bits, seen only through core writes
  logic       ie_ff;
  logic [7:0] en_ff;
  logic [7:0] cfg_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ie_ff  <= 1'b0;
      en_ff  <= 8'h00;
      cfg_ff <= 8'h00;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == 8'ha9) ie_ff <= sfr_req.wdata[1];
      if (sfr_req.addr == 8'hec) en_ff <= sfr_req.wdata;
      if (sfr_req.addr == 8'hf5) cfg_ff <= sfr_req.wdata;
    end
  end
  // ==================================================
  // properties; the margins cover the two-flop input sync
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_adc; metering_adc_avail == rail_on_main; endproperty
  a_adc: assert property (p_adc) else $error("adc availability differs from source");
  property p_dis; cfg_ff[1] && rail_on_main |=> rail_on_main; endproperty
  a_dis: assert property (p_dis) else $error("left main while disabled");
  property p_src; sfr_req.rd && sfr_req.addr == 8'hf4 |=> sfr_rdata[6] == $past(rail_on_main);
  endproperty
  a_src: assert property (p_src) else $error("source bit wrong");
  property p_main; (!main_ok_async && cfg_ff[1:0] == 2'b00)[*8] |-> !rail_on_main; endproperty
  a_main: assert property (p_main) else $error("no switch on main loss");
  property p_ieoff; !ie_ff [*3] |-> !power_irq; endproperty
  a_ieoff: assert property (p_ieoff) else $error("irq while gated off");
  property p_swo; $fell(rail_on_main) && ie_ff && en_ff[1] |-> ##[1:3] power_irq; endproperty
  a_swo: assert property (p_swo) else $error("no irq on switchover");
  property p_rst; $rose(rail_on_main) && ie_ff && en_ff[7] |-> ##[1:3] power_irq; endproperty
  a_rst: assert property (p_rst) else $error("no irq on restore");
  property p_back; $rose(rail_on_main) && !cfg_ff[1] |-> $past(main_ok_async, 3); endproperty
  a_back: assert property (p_back) else $error("returned without main supply");
  property p_wait; $rose(rail_on_main) |-> !$past(rail_on_main, RESTORE_CYC); endproperty
  a_wait: assert property (p_wait) else $error("restore wait too short");
  property p_conv; sfr_req.wr && sfr_req.addr == 8'hd8 |=> dc_conv_start; endproperty
  a_conv: assert property (p_conv) else $error("no conversion start");
endmodule
bind sso_top sso_top_asserts #(.RESTORE_CYC(RESTORE_CYC)) i_sso_top_asserts (
  .clk, .nrst, .sfr_req, .sfr_rdata, .main_ok_async, .rail_on_main,
  .metering_adc_avail, .dc_conv_start, .power_irq
);
`default_nettype wire

// file: verif/sso_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sso_top_tb_top;
  import sso_pkg::*;
  // ==================================================
  // stimulus, partner and design
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  sso_sfr_req_t req = '0;
  sso_evt_t     evt = '0;
  logic [2:0]   want = 3'h7;
  logic         slow = 1'b0;
  logic [2:0]   lvl;
  logic [7:0]   rdata, snap_rd, en;
  logic         rail, adc_ok, conv, irq, snap_cv;
  int           bad_count = 0;
  int           checked = 0;
  int           n;
  logic [7:0]   adr [7] = '{8'ha9, 8'hec, 8'hf4, 8'hf5, 8'hf8, 8'hff, 8'h80};
  int           fb [6] = '{0, 3, 3, 2, 2, 5};
  always #12.5 clk = ~clk;
  sso_partner i_sso_partner (.clk(clk), .slow(slow), .want(want), .lvl(lvl));
  sso_top #(.DC_CYC(8), .RESTORE_CYC(20)) i_sso_top (.clk(clk), .nrst(nrst),
    .sfr_req(req), .sfr_rdata(rdata), .main_ok_async(lvl[2]), .dc_ok_async(lvl[1]),
    .batt_ctrl_async(lvl[0]), .evt(evt), .rail_on_main(rail), .metering_adc_avail(adc_ok),
    .dc_conv_start(conv), .power_irq(irq));
  // ==================================================
  // helpers; inputs move 1 ns after the rising edge
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // rule view of the shared request: gate bit and any enabled flag
  function automatic logic exp_irq(input logic [7:0] flg, input logic [7:0] ena,
                                   input logic ie);
    return ie && (|(flg & ena));
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one core access; an idle cycle follows so requests never merge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = v;
    cyc(1);
    snap_rd = rdata;
    snap_cv = conv;
    req = '0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), snap_rd, exp);
  endtask
  // bounded wait for the rail source, n counts the cycles
  task automatic wait_rail(input logic exp);
    n = 0;
    while (rail !== exp && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // ==================================================
  // main sequence
  initial begin
    void'($urandom(32'h5a3dd636));
    cyc(16);
    nrst = 1'b1;
    cyc(3);
    foreach (adr[i]) rdc(adr[i], (adr[i] == 8'hf4) ? 8'h40 : 8'h00);
    acc(1'b1, 8'ha9, 8'h02);
    // every event source, random enable mask, gate and clear
    for (int k = 0; k < 6; k++) begin
      en = 8'($urandom);
      evt = sso_evt_t'(6'h20 >> k);
      cyc(1);
      evt = '0;
      rdc(8'hf8, 8'h01 << fb[k]);
      acc(1'b1, 8'hec, en);
      cyc(2);
      chk("irq", 8'(irq), 8'(exp_irq(8'h01 << fb[k], en, 1'b1)));
      acc(1'b1, 8'ha9, 8'h00);
      cyc(2);
      chk("irq gated", 8'(irq), 8'(exp_irq(8'h01 << fb[k], en, 1'b0)));
      acc(1'b1, 8'ha9, 8'h02);
      acc(1'b1, 8'hf8, 8'h00);
      rdc(8'hf8, 8'h00);
    end
    // main supply loss and return
    acc(1'b1, 8'hec, 8'h82);
    want = 3'b011;
    wait_rail(1'b0);
    chk("adc", 8'(adc_ok), 8'h00);
    rdc(8'hf4, 8'h00);
    rdc(8'hf8, 8'h02);
    chk("irq swo", 8'(irq), 8'h01);
    acc(1'b1, 8'hf8, 8'h00);
    want = 3'b111;
    wait_rail(1'b1);
    chk("restore wait", 8'(n >= 20 && n <= 24), 8'h01);
    rdc(8'hf8, 8'h80);
    // dc supervisory loss, dc still low keeps battery
    acc(1'b1, 8'hf5, 8'h01);
    want = 3'b101;
    wait_rail(1'b0);
    chk("dc delay", 8'(n >= 8 && n <= 12), 8'h01);
    cyc(40);
    chk("dc hold", 8'(rail), 8'h00);
    want = 3'b111;
    wait_rail(1'b1);
    // a dc dip shorter than the delay leaves the rail on main
    want = 3'b101;
    cyc(4);
    want = 3'b111;
    cyc(20);
    chk("dc abort", 8'(rail), 8'h01);
    // pin falling edge with a slow far side, low pin keeps battery
    slow = 1'b1;
    acc(1'b1, 8'hf5, 8'h00);
    acc(1'b1, 8'hff, {4'h0, 1'($urandom), 3'h2});
    want = 3'b110;
    wait_rail(1'b0);
    cyc(40);
    chk("pin hold", 8'(rail), 8'h00);
    want = 3'b111;
    wait_rail(1'b1);
    slow = 1'b0;
    // disabled switchover keeps main supply
    acc(1'b1, 8'hf5, 8'h02);
    want = 3'b011;
    cyc(40);
    chk("disabled", 8'(rail), 8'h01);
    want = 3'b111;
    acc(1'b1, 8'hd8, 8'h00);
    chk("conv start", 8'(snap_cv), 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
